//--- logic/protection_check_pkg.sv
`default_nettype none

package protection_check_pkg;

    // ----------------------------------------------------------------
    // sizes and widths
    // ----------------------------------------------------------------
    localparam int ENTRY_COUNT_MAX = 16;
    localparam int CFG_BYTE_W = 8;
    localparam int REG_WIDTH_RV32 = 32;
    localparam int REG_WIDTH_RV64 = 64;
    localparam int REG_WIDTH_MAX = 64;
    localparam int PHYS_ADDR_RV32 = 34;
    localparam int PHYS_ADDR_RV64 = 56;
    localparam int PHYS_ADDR_MAX = 56;
    localparam int ADDR_LSB = 2;
    localparam int CFG_PER_WORD32 = 4;
    localparam int CSR_ADDR_W = 12;
    localparam int RANGE_W = 66;

    // ----------------------------------------------------------------
    // control register numbers and reset values
    // ----------------------------------------------------------------
    localparam logic [CSR_ADDR_W-1:0] CSR_CFG_BASE = 12'h3A0;
    localparam logic [CSR_ADDR_W-1:0] CSR_CFG_COUNT = 12'h004;
    localparam logic [CSR_ADDR_W-1:0] CSR_ADDR_BASE = 12'h3B0;
    localparam logic [1:0] CFG_RESERVED_ZERO = 2'h0;
    localparam logic [CFG_BYTE_W-1:0] CFG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        mode_off = 2'b00,
        top_of_range_mode = 2'b01,
        aligned_four_byte_mode = 2'b10,
        aligned_power_of_two_mode = 2'b11
    } match_mode_e;

    typedef enum logic [1:0] {
        priv_user = 2'b00,
        priv_super = 2'b01,
        priv_reserved = 2'b10,
        priv_machine = 2'b11
    } priv_e;

    typedef enum logic [1:0] {
        access_fetch = 2'b00,
        access_load = 2'b01,
        access_store = 2'b10,
        access_none = 2'b11
    } access_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic lock;
        logic [1:0] reserved;
        match_mode_e mode;
        logic x;
        logic w;
        logic r;
    } entry_cfg_s;

    typedef struct packed {
        logic valid;
        access_e kind;
        logic [2:0] size;
        logic [PHYS_ADDR_MAX-1:0] addr;
    } access_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [CSR_ADDR_W-1:0] addr;
        logic [REG_WIDTH_MAX-1:0] wdata;
    } csr_req_s;

endpackage : protection_check_pkg

`default_nettype wire

//--- logic/physical_memory_protection_check.sv
// Function
// - sixteen entries, config byte plus address register
// - registers reachable only from machine mode
// - narrow width packs four bytes per word
// - wide width uses words 0,2; 1,3 illegal
// - narrow address register holds bits 33:2
// - wide address register holds bits 55:2
// - read/write/execute bits grant each access type
// - mode decode off, range top, four, power-of-two
// - mode zero disables the entry
// - range top spans previous bound to own
// - entry zero range top starts at zero
// - trailing ones set power-of-two region size
// - lock ignores writes to config and address
// - lock stays set until reset
// - locked range top also freezes previous address
// - unlocked machine access succeeds, else permission decides
// - lowest matching entry alone decides
// - partial cover fails the access
// - no match: machine passes, others fail
// - failure raises fault of matching access type
// - all state updates on rising clock edge
// - asynchronous low reset returns initial state
`default_nettype none

module physical_memory_protection_check
    import protection_check_pkg::*;
#(
    parameter int REGISTER_WIDTH = 32,
    parameter int ENTRY_COUNT = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire priv_e i_priv,
    input wire csr_req_s i_csr,
    output logic [REGISTER_WIDTH-1:0] o_csr_rdata,
    output logic o_csr_ack,
    output logic o_csr_err,
    input wire access_req_s i_fetch,
    input wire access_req_s i_data,
    output logic o_fetch_fault,
    output logic o_load_fault,
    output logic o_store_fault
);

    // ----------------------------------------------------------------
    // derived sizes
    // ----------------------------------------------------------------
    localparam bit WIDE = (REGISTER_WIDTH == REG_WIDTH_RV64);
    localparam int PHYS_W = WIDE ? PHYS_ADDR_RV64 : PHYS_ADDR_RV32;
    localparam int ADDR_BITS = PHYS_W - ADDR_LSB;
    localparam int BYTES_PER_CSR = REGISTER_WIDTH / CFG_BYTE_W;

    // ----------------------------------------------------------------
    // entry state
    // ----------------------------------------------------------------
    entry_cfg_s cfg_reg [ENTRY_COUNT];
    entry_cfg_s cfg_next [ENTRY_COUNT];
    logic [ADDR_BITS-1:0] addr_reg [ENTRY_COUNT];
    logic [ADDR_BITS-1:0] addr_next [ENTRY_COUNT];
    logic [REGISTER_WIDTH-1:0] rdata_reg;
    logic [REGISTER_WIDTH-1:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic err_reg;
    logic err_next;

    // ----------------------------------------------------------------
    // access lookup
    // ----------------------------------------------------------------
    // walk entries in order; first hit alone decides
    function automatic logic access_fails(input access_req_s req, input access_e kind,
                                          input priv_e priv);
        logic [RANGE_W-1:0] first_w;
        logic [RANGE_W-1:0] last_w;
        logic [RANGE_W-1:0] end_b;
        logic [RANGE_W-1:0] base_w;
        logic [RANGE_W-1:0] top_w;
        logic [RANGE_W-1:0] mask_w;
        logic [RANGE_W-1:0] cur_w;
        logic [RANGE_W-1:0] prev_w;
        logic found;
        logic fail;
        logic perm;
        logic covers;
        found = 1'b0;
        fail = 1'b0;
        perm = 1'b0;
        covers = 1'b0;
        base_w = '0;
        top_w = '0;
        mask_w = '0;
        prev_w = '0;
        end_b = RANGE_W'(req.addr[PHYS_W-1:0]) + (RANGE_W'(1) << req.size) - RANGE_W'(1);
        first_w = RANGE_W'(req.addr[PHYS_W-1:0]) >> ADDR_LSB;
        last_w = end_b >> ADDR_LSB;
        for (int i = 0; i < ENTRY_COUNT; i++) begin
            cur_w = RANGE_W'(addr_reg[i]);
            unique case (cfg_reg[i].mode)
                mode_off: begin
                    base_w = '0;
                    top_w = '0;
                end
                top_of_range_mode: begin
                    base_w = prev_w;
                    top_w = cur_w;
                end
                aligned_four_byte_mode: begin
                    base_w = cur_w;
                    top_w = cur_w + RANGE_W'(1);
                end
                aligned_power_of_two_mode: begin
                    mask_w = cur_w ^ (cur_w + RANGE_W'(1));
                    base_w = cur_w & ~mask_w;
                    top_w = base_w + mask_w + RANGE_W'(1);
                end
            endcase
            // any byte inside the region makes this entry the decider
            if (!found && (base_w < top_w) && (first_w < top_w) && (last_w >= base_w)) begin
                found = 1'b1;
                covers = (first_w >= base_w) && (last_w < top_w);
                unique case (kind)
                    access_fetch: perm = cfg_reg[i].x;
                    access_load: perm = cfg_reg[i].r;
                    access_store: perm = cfg_reg[i].w;
                    access_none: perm = 1'b0;
                endcase
                fail = !covers
                       || ((cfg_reg[i].lock || (priv != priv_machine)) && !perm);
            end
            prev_w = cur_w;
        end
        if (!found) begin
            fail = (priv != priv_machine) && (ENTRY_COUNT > 0);
        end
        return req.valid && fail;
    endfunction : access_fails

    // ----------------------------------------------------------------
    // fault outputs, same cycle as the address
    // ----------------------------------------------------------------
    // data faults split by the requested kind
    always_comb begin
        o_fetch_fault = access_fails(i_fetch, access_fetch, i_priv);
        o_load_fault = (i_data.kind == access_load)
                       && access_fails(i_data, access_load, i_priv);
        o_store_fault = (i_data.kind == access_store)
                        && access_fails(i_data, access_store, i_priv);
    end

    // ----------------------------------------------------------------
    // control register access
    // ----------------------------------------------------------------
    // decode, lock filtering and read-back of the old value
    always_comb begin
        logic [CSR_ADDR_W-1:0] cfg_off;
        logic [CSR_ADDR_W-1:0] addr_off;
        logic is_cfg;
        logic is_addr;
        logic illegal;
        logic frozen;
        logic [CFG_BYTE_W-1:0] wbyte;
        entry_cfg_s nb;
        int e;
        int n;
        cfg_off = i_csr.addr - CSR_CFG_BASE;
        addr_off = i_csr.addr - CSR_ADDR_BASE;
        is_cfg = (i_csr.addr >= CSR_CFG_BASE) && (cfg_off < CSR_CFG_COUNT);
        is_addr = (i_csr.addr >= CSR_ADDR_BASE)
                  && (addr_off < CSR_ADDR_W'(ENTRY_COUNT));
        illegal = (i_priv != priv_machine)
                  || (is_cfg && WIDE && cfg_off[0]);
        frozen = 1'b0;
        wbyte = '0;
        nb = '0;
        e = 0;
        n = 0;
        cfg_next = cfg_reg;
        addr_next = addr_reg;
        rdata_next = '0;
        ack_next = 1'b0;
        err_next = 1'b0;
        if (i_csr.valid && (is_cfg || is_addr)) begin
            err_next = illegal;
            ack_next = !illegal;
            if (!illegal && is_cfg) begin
                // entry number is word*4+lane for both widths
                for (int k = 0; k < BYTES_PER_CSR; k++) begin
                    e = int'(cfg_off) * CFG_PER_WORD32 + k;
                    if (e < ENTRY_COUNT) begin
                        rdata_next[k*CFG_BYTE_W +: CFG_BYTE_W] = cfg_reg[e];
                        wbyte = i_csr.wdata[k*CFG_BYTE_W +: CFG_BYTE_W];
                        nb = entry_cfg_s'(wbyte);
                        nb.reserved = CFG_RESERVED_ZERO;
                        if (i_csr.write && !cfg_reg[e].lock) begin
                            cfg_next[e] = nb;
                        end
                    end
                end
            end
            if (!illegal && is_addr) begin
                n = int'(addr_off);
                rdata_next = REGISTER_WIDTH'(addr_reg[n]);
                frozen = cfg_reg[n].lock;
                if (n + 1 < ENTRY_COUNT) begin
                    frozen = frozen || (cfg_reg[n+1].lock
                             && (cfg_reg[n+1].mode == top_of_range_mode));
                end
                if (i_csr.write && !frozen) begin
                    addr_next[n] = i_csr.wdata[ADDR_BITS-1:0];
                end
            end
        end
    end

    // register update; reset unlocks and disables every entry
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < ENTRY_COUNT; i++) begin
                cfg_reg[i] <= entry_cfg_s'(CFG_RESET);
                addr_reg[i] <= '0;
            end
            rdata_reg <= '0;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            addr_reg <= addr_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
        end
    end

    assign o_csr_rdata = rdata_reg;
    assign o_csr_ack = ack_reg;
    assign o_csr_err = err_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic any_on;

    // some entry is enabled
    always_comb begin
        any_on = 1'b0;
        for (int i = 0; i < ENTRY_COUNT; i++) begin
            any_on = any_on || (cfg_reg[i].mode != mode_off);
        end
    end

    // per-entry lock and reset checks
    for (genvar g = 0; g < ENTRY_COUNT; g++) begin : gen_lock_checks
        AST_LOCK_STICKY:
        assert property (@(posedge i_clk) disable iff (!i_reset_n)
            cfg_reg[g].lock |=> cfg_reg[g].lock)
            else $error("lock bit dropped without reset");
        AST_LOCKED_CFG_HOLD:
        assert property (@(posedge i_clk) disable iff (!i_reset_n)
            cfg_reg[g].lock |=> $stable(cfg_reg[g]))
            else $error("locked config byte changed");
        AST_LOCKED_ADDR_HOLD:
        assert property (@(posedge i_clk) disable iff (!i_reset_n)
            cfg_reg[g].lock |=> $stable(addr_reg[g]))
            else $error("locked address register changed");
        AST_RESET_CLEARS:
        assert property (@(posedge i_clk)
            !i_reset_n |=> (!cfg_reg[g].lock && (cfg_reg[g].mode == mode_off)))
            else $error("entry not cleared by reset");
        if (g + 1 < ENTRY_COUNT) begin : gen_tor
            AST_TOR_PREV_HOLD:
            assert property (@(posedge i_clk) disable iff (!i_reset_n)
                (cfg_reg[g+1].lock && (cfg_reg[g+1].mode == top_of_range_mode))
                |=> $stable(addr_reg[g]))
                else $error("lower bound of locked range changed");
        end
    end

    // non-machine write is refused and changes nothing
    AST_NON_MACHINE_REFUSED:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_csr.valid && i_csr.write && (i_csr.addr == CSR_ADDR_BASE)
         && (i_priv != priv_machine))
        |=> (o_csr_err && !o_csr_ack && $stable(addr_reg[0])))
        else $error("non-machine write was not refused");

    AST_NO_MATCH_MACHINE:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_fetch.valid && (i_priv == priv_machine) && !any_on) |-> !o_fetch_fault)
        else $error("machine fetch faulted with no entry enabled");

    AST_NO_MATCH_LOWER:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_data.valid && (i_priv != priv_machine) && !any_on
         && (i_data.kind inside {access_load, access_store}))
        |-> (o_load_fault || o_store_fault))
        else $error("lower privilege access passed with no entry");

    // lower privilege fetch with nothing enabled must fault
    AST_NO_MATCH_FETCH_LOWER:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_fetch.valid && (i_priv != priv_machine) && !any_on) |-> o_fetch_fault)
        else $error("lower privilege fetch passed with no entry");

    // an idle port never reports a fault
    AST_IDLE_NO_FAULT:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!i_fetch.valid |-> !o_fetch_fault)
        and (!i_data.valid |-> !(o_load_fault || o_store_fault)))
        else $error("fault raised on an idle port");

    // one data access raises at most one fault
    AST_ONE_DATA_FAULT:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(o_load_fault && o_store_fault))
        else $error("load and store fault raised together");

    // a register access gets at most one kind of answer
    AST_CSR_ONE_ANSWER:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(o_csr_ack && o_csr_err))
        else $error("register access both accepted and refused");

    // an answer only follows a request of the previous cycle
    AST_ANSWER_FOLLOWS_REQ:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_csr_ack || o_csr_err) |-> $past(i_csr.valid))
        else $error("register answer without request");

    // machine access to the first config word is accepted
    AST_MACHINE_CFG_ACK:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_csr.valid && (i_priv == priv_machine) && (i_csr.addr == CSR_CFG_BASE))
        |=> (o_csr_ack && !o_csr_err))
        else $error("machine config access not accepted");

    // words just past the mapped ranges get no answer
    AST_UNMAPPED_SILENT:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_csr.valid && ((i_csr.addr == (CSR_CFG_BASE + CSR_CFG_COUNT))
         || (i_csr.addr == (CSR_ADDR_BASE + CSR_ADDR_W'(ENTRY_COUNT)))))
        |=> (!o_csr_ack && !o_csr_err))
        else $error("unmapped register access was answered");

    // refused or idle cycles return no read data
    AST_NO_DATA_WITHOUT_ACK:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !o_csr_ack |-> (o_csr_rdata == '0))
        else $error("read data shown without acceptance");

    AST_FAULT_KIND:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_store_fault |-> (i_data.valid && (i_data.kind == access_store)))
        and (o_load_fault |-> (i_data.valid && (i_data.kind == access_load))))
        else $error("fault raised for wrong access kind");

    AST_MACHINE_UNLOCKED_PASS:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_data.valid && (i_priv == priv_machine) && (i_data.size == 3'h0)
         && (cfg_reg[0].mode == aligned_four_byte_mode) && !cfg_reg[0].lock
         && (i_data.addr[PHYS_W-1:ADDR_LSB] == addr_reg[0]))
        |-> (!o_load_fault && !o_store_fault))
        else $error("unlocked machine access to first entry faulted");

    if (WIDE) begin : gen_wide_checks
        AST_ODD_CFG_ILLEGAL:
        assert property (@(posedge i_clk) disable iff (!i_reset_n)
            (i_csr.valid && (i_priv == priv_machine)
             && (i_csr.addr == (CSR_CFG_BASE + CSR_CFG_COUNT - 12'h001)))
            |=> (o_csr_err && !o_csr_ack))
            else $error("odd config word accepted at wide width");
    end

endmodule : physical_memory_protection_check

`default_nettype wire

//--- tb/cpu_model.sv
`default_nettype none
// ----------------------------------------------------------------
// requester side: privilege, register accesses, memory checks
// ----------------------------------------------------------------
module cpu_model
    import protection_check_pkg::*;
(
    input wire logic i_clk,
    input wire logic [31:0] i_csr_rdata,
    input wire logic i_csr_ack,
    input wire logic i_csr_err,
    input wire logic i_fetch_fault,
    input wire logic i_load_fault,
    input wire logic i_store_fault,
    output var priv_e o_priv,
    output var csr_req_s o_csr,
    output var access_req_s o_fetch,
    output var access_req_s o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle requests from time zero
    initial begin
        o_priv = priv_machine;
        o_csr = '0;
        o_fetch = '0;
        o_data = '0;
    end
    // one register access held over one rising edge, answer read a cycle later
    task automatic csr_op(input priv_e p, input logic wr, input logic [11:0] a,
            input logic [31:0] d, input int gap, output logic [33:0] res);
        repeat (gap) @(negedge i_clk);
        @(negedge i_clk);
        o_priv = p;
        o_csr = '{valid: 1'b1, write: wr, addr: a, wdata: {32'h0, d}};
        @(negedge i_clk);
        o_csr.valid = 1'b0;
        o_csr.addr = ~o_csr.addr; // released lines do not keep old values
        o_csr.wdata = ~o_csr.wdata;
        res = {i_csr_err, i_csr_ack, i_csr_ack ? i_csr_rdata : 32'h0};
    endtask : csr_op
    // one memory check held over a rising edge; the answer is combinational
    task automatic access(input priv_e p, input access_e k, input logic [33:0] a,
            input logic [2:0] sz, output logic [2:0] f);
        access_req_s req;
        req = '{valid: 1'b1, kind: k, size: sz, addr: {22'h0, a}};
        @(negedge i_clk);
        o_priv = p;
        if (k == access_fetch) o_fetch = req;
        else o_data = req;
        @(negedge i_clk);
        f = {i_fetch_fault, i_load_fault, i_store_fault};
        o_fetch.valid = 1'b0;
        o_data.valid = 1'b0;
    endtask : access
endmodule : cpu_model
`default_nettype wire

//--- tb/physical_memory_protection_check_tb.sv
`default_nettype none
module physical_memory_protection_check_tb
    import protection_check_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // clock, reset, wiring
    // ----------------------------------------------------------------
    localparam priv_e mach = priv_machine;
    localparam priv_e usr = priv_user;
    localparam logic [33:0] refused = {2'b10, 32'h0};
    logic i_clk;
    logic i_reset_n;
    priv_e priv;
    csr_req_s csr;
    access_req_s fetch_req;
    access_req_s data_req;
    logic [31:0] rdata;
    logic ack, err, f_fault, l_fault, s_fault;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    physical_memory_protection_check #(.REGISTER_WIDTH(32), .ENTRY_COUNT(16)) u_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_priv(priv), .i_csr(csr),
        .o_csr_rdata(rdata), .o_csr_ack(ack), .o_csr_err(err), .i_fetch(fetch_req),
        .i_data(data_req), .o_fetch_fault(f_fault), .o_load_fault(l_fault),
        .o_store_fault(s_fault));
    cpu_model u_cpu (
        .i_clk(i_clk), .i_csr_rdata(rdata), .i_csr_ack(ack), .i_csr_err(err),
        .i_fetch_fault(f_fault), .i_load_fault(l_fault), .i_store_fault(s_fault),
        .o_priv(priv), .o_csr(csr), .o_fetch(fetch_req), .o_data(data_req));
    // ----------------------------------------------------------------
    // compare, report and access helpers
    // ----------------------------------------------------------------
    function automatic logic [33:0] ok(input logic [31:0] v);
        return {2'b01, v};
    endfunction : ok
    task automatic chk_data(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_fault(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t fault got %h exp %h", $time, got, exp);
        end
    endtask : chk_fault
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic csr_chk(input priv_e p, input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [33:0] exp);
        logic [33:0] res;
        u_cpu.csr_op(p, wr, a, d, 0, res);
        chk_data(res, exp);
    endtask : csr_chk
    task automatic acc_chk(input priv_e p, input access_e k, input logic [33:0] a,
            input logic [2:0] sz, input logic [2:0] exp);
        logic [2:0] f;
        u_cpu.access(p, k, a, sz, f);
        chk_fault(f, exp);
    endtask : acc_chk
    // reset state: all entries off
    task automatic t_reset_state();
        csr_chk(mach, 1'b0, 12'h3A0, 32'h0, ok(32'h0));
        csr_chk(mach, 1'b0, 12'h3BF, 32'h0, ok(32'h0));
        acc_chk(mach, access_load, 34'h100, 3'h2, 3'b000);
        acc_chk(mach, access_fetch, 34'h100, 3'h2, 3'b000);
        acc_chk(usr, access_load, 34'h100, 3'h2, 3'b010);
        acc_chk(usr, access_fetch, 34'h100, 3'h2, 3'b100);
        acc_chk(priv_super, access_store, 34'h100, 3'h2, 3'b001);
    endtask : t_reset_state
    // entry 0 top of range, read only, slow request
    task automatic t_tor_regs();
        logic [33:0] res;
        u_cpu.csr_op(mach, 1'b1, 12'h3B0, 32'h40, 3, res);
        chk_data(res, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3A0, 32'h69, ok(32'h0));
        csr_chk(mach, 1'b0, 12'h3A0, 32'h0, ok(32'h9));
        csr_chk(mach, 1'b0, 12'h3B0, 32'h0, ok(32'h40));
        acc_chk(usr, access_load, 34'h0, 3'h2, 3'b000);
        acc_chk(usr, access_load, 34'hFC, 3'h2, 3'b000);
        acc_chk(usr, access_store, 34'hFC, 3'h2, 3'b001);
        acc_chk(usr, access_load, 34'h100, 3'h2, 3'b010);
        acc_chk(mach, access_store, 34'hFC, 3'h2, 3'b000);
    endtask : t_tor_regs
    // power-of-two, four-byte regions and priority
    task automatic t_aligned_power_of_two_mode_prio();
        csr_chk(mach, 1'b1, 12'h3B1, 32'h81, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3B2, 32'h82, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3B4, 32'h100, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3B5, 32'h140, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3A0, 32'h00111C09, ok(32'h9));
        csr_chk(mach, 1'b1, 12'h3A1, 32'h00001911, ok(32'h0));
        acc_chk(usr, access_fetch, 34'h20C, 3'h2, 3'b000);
        acc_chk(usr, access_fetch, 34'h210, 3'h2, 3'b100);
        acc_chk(usr, access_fetch, 34'h208, 3'h2, 3'b000);
        acc_chk(usr, access_load, 34'h20C, 3'h3, 3'b010);
        acc_chk(usr, access_load, 34'h400, 3'h2, 3'b000);
        acc_chk(usr, access_load, 34'h404, 3'h2, 3'b010);
        acc_chk(usr, access_load, 34'h504, 3'h2, 3'b000);
        acc_chk(usr, access_load, 34'h508, 3'h2, 3'b010);
    endtask : t_aligned_power_of_two_mode_prio
    // locked top-of-range entry 3
    task automatic t_lock();
        csr_chk(mach, 1'b1, 12'h3B3, 32'h100, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3A0, 32'h89111C09, ok(32'h00111C09));
        csr_chk(mach, 1'b1, 12'h3B2, 32'h0, ok(32'h82));
        csr_chk(mach, 1'b0, 12'h3B2, 32'h0, ok(32'h82));
        csr_chk(mach, 1'b1, 12'h3B3, 32'h7, ok(32'h100));
        csr_chk(mach, 1'b0, 12'h3B3, 32'h0, ok(32'h100));
        csr_chk(mach, 1'b1, 12'h3A0, 32'h00111C0B, ok(32'h89111C09));
        csr_chk(mach, 1'b0, 12'h3A0, 32'h0, ok(32'h89111C0B));
        acc_chk(mach, access_store, 34'h300, 3'h2, 3'b001);
        acc_chk(mach, access_load, 34'h300, 3'h2, 3'b000);
    endtask : t_lock
    // refused and unmapped register accesses
    task automatic t_refuse();
        csr_chk(usr, 1'b1, 12'h3B0, 32'hDEAD, refused);
        csr_chk(priv_super, 1'b0, 12'h3A0, 32'h0, refused);
        csr_chk(mach, 1'b0, 12'h3B0, 32'h0, ok(32'h40));
        csr_chk(mach, 1'b0, 12'h3C0, 32'h0, 34'h0);
        csr_chk(mach, 1'b1, 12'h3A4, 32'h0, 34'h0);
    endtask : t_refuse
    // asynchronous reset mid-run clears locks
    task automatic t_reset_mid();
        @(negedge i_clk);
        i_reset_n = 1'b0;
        @(negedge i_clk);
        i_reset_n = 1'b1;
        csr_chk(mach, 1'b0, 12'h3A0, 32'h0, ok(32'h0));
        csr_chk(mach, 1'b0, 12'h3B2, 32'h0, ok(32'h0));
        acc_chk(usr, access_load, 34'h300, 3'h2, 3'b010);
        csr_chk(mach, 1'b1, 12'h3B0, 32'h50, ok(32'h0));
        csr_chk(mach, 1'b1, 12'h3A0, 32'h10, ok(32'h0));
        acc_chk(mach, access_load, 34'h141, 3'h0, 3'b000);
        acc_chk(usr, access_load, 34'h141, 3'h0, 3'b010);
    endtask : t_reset_mid
    // hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end
    // main sequence
    initial begin
        i_reset_n = 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_reset_n = 1'b1;
        t_reset_state();
        t_tor_regs();
        t_aligned_power_of_two_mode_prio();
        t_lock();
        t_refuse();
        t_reset_mid();
        close_out();
    end
endmodule : physical_memory_protection_check_tb
`default_nettype wire
